// ### rtl/cmt_cap_if.sv
// carrier between the timer core and its capture pin unit
// assumes one clock domain, pins already synchronous
`default_nettype none
interface cmt_cap_if;
   logic [cmt_pkg::NPIN-1:0] pins;
   logic [cmt_pkg::NCH-1:0][cmt_pkg::NPIN-1:0] sel;
   logic [cmt_pkg::NCH-1:0] and_mode;
   logic [cmt_pkg::NCH-1:0] rise_en;
   logic [cmt_pkg::NCH-1:0] fall_en;
   logic [cmt_pkg::NCH-1:0] event_hit;
   modport core (output pins, output sel, output and_mode, output rise_en, output fall_en,
      input event_hit);
   modport unit (input pins, input sel, input and_mode, input rise_en, input fall_en,
      output event_hit);
endinterface
`default_nettype wire

// ### rtl/cmt_capture_unit.sv
// capture pin combiner and transition detector, one channel per loop entry
// assumes capture pins are synchronous to pclk
`default_nettype none
module cmt_capture_unit (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // core side
   cmt_cap_if.unit cap
);
   typedef struct packed {
      logic [cmt_pkg::NCH-1:0] level;
      logic [cmt_pkg::NCH-1:0] hit;
   } cmt_cu_state_t;

   cmt_cu_state_t s;
   cmt_cu_state_t next_s;
   logic [cmt_pkg::NCH-1:0] comb_lvl;

   // per channel pin merge: several pins feed one capture input
   genvar g;
   generate
      for (g = 0; g < cmt_pkg::NCH; g++) begin : g_ch
         assign comb_lvl[g] = cap.and_mode[g] ?
            ((&(cap.pins | ~cap.sel[g])) & (|cap.sel[g])) : // [RULE9]
            (|(cap.pins & cap.sel[g]));                     // [RULE9]
      end
   endgenerate

   // edge detect on the merged level
   always_comb begin
      next_s = s;
      next_s.level = comb_lvl;
      next_s.hit = (cap.rise_en & comb_lvl & ~s.level) |
         (cap.fall_en & ~comb_lvl & s.level); // [RULE2]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign cap.event_hit = s.hit;
endmodule // cmt_capture_unit
`default_nettype wire

// ### rtl/cmt_pkg.sv
// constants of the capture/match timer: register map, fields, reset values
// assumes an apb master with 32-bit data and byte addresses on paddr
// Behaviour
// RULE1: 32-bit counter advanced through 32-bit prescaler
// RULE2: four capture channels snapshot count on transitions
// RULE3: four match registers compared with the counter
// RULE4: match may keep counting, optional interrupt
// RULE5: match may halt counter, optional interrupt
// RULE6: match may zero counter for periodic operation
// RULE7: four match outputs: low, high, toggle, hold
// RULE8: optional counting of external clock edges
// RULE9: pins combine by or/and, outputs broadcast
// RULE10: all flags merge onto one interrupt line
// RULE11: prescaler wraps at limit, then counter increments
`default_nettype none
package cmt_pkg;
   localparam int NCH = 4;
   localparam int NPIN = 4;
   // register byte offsets
   localparam logic [7:0] OFS_FLAGS = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_COUNT = 8'h08;
   localparam logic [7:0] OFS_PRE_LIM = 8'h0c;
   localparam logic [7:0] OFS_PRE_CNT = 8'h10;
   localparam logic [7:0] OFS_MATCH_CTRL = 8'h14;
   localparam logic [7:0] OFS_MATCH0 = 8'h18;
   localparam logic [7:0] OFS_CAP_CTRL = 8'h28;
   localparam logic [7:0] OFS_CAP0 = 8'h2c;
   localparam logic [7:0] OFS_EXT_MATCH = 8'h3c;
   localparam logic [7:0] OFS_CNT_MODE = 8'h40;
   localparam logic [7:0] OFS_CAP_ROUTE = 8'h44;
   localparam logic [7:0] OFS_OUT_ROUTE = 8'h48;
   localparam logic [7:0] OFS_LAST = 8'h48;
   // control bits
   localparam int CTRL_EN = 0;
   localparam int CTRL_RST = 1;
   // match control: three bits per channel
   localparam int MC_INT = 0;
   localparam int MC_RST = 1;
   localparam int MC_STOP = 2;
   // capture control: three bits per channel
   localparam int CC_RISE = 0;
   localparam int CC_FALL = 1;
   localparam int CC_INT = 2;
   // external match: state in [3:0], two action bits per channel from bit 4
   localparam int EM_ACT = 4;
   localparam logic [1:0] ACT_HOLD = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   // counting source
   localparam logic [1:0] MODE_PCLK = 2'h0;
   localparam logic [1:0] MODE_EXT_RISE = 2'h1;
   localparam logic [1:0] MODE_EXT_FALL = 2'h2;
   localparam logic [1:0] MODE_EXT_BOTH = 2'h3;
   // capture route: pin mask 4 bits per channel, and-mode bits from 16
   localparam int CR_AND = 16;
   // flags: match in [3:0], capture in [7:4]
   localparam int FL_CAP = 4;
   // reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [15:0] RST_CAP_ROUTE = 16'h8421;
   localparam logic [7:0] RST_OUT_ROUTE = 8'he4;
endpackage
`default_nettype wire

// ### rtl/cmt_timer.sv
// capture/match timer top: apb register file, prescaler, counter, match logic
// assumes apb master per protocol; pins synchronous to pclk
`default_nettype none
module cmt_timer (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins
   input wire logic [cmt_pkg::NPIN-1:0] cap_pin,
   input wire logic cnt_clk_in,
   output logic [cmt_pkg::NPIN-1:0] match_pin,
   // interrupt request
   output logic irq
);
   localparam int NCH = cmt_pkg::NCH;
   localparam int NPIN = cmt_pkg::NPIN;

   typedef struct packed {
      logic en;
      logic cnt_rst;
      logic [31:0] count;
      logic [31:0] pre_lim;
      logic [31:0] pre_cnt;
      logic [3*NCH-1:0] match_ctrl;
      logic [NCH-1:0][31:0] match_val;
      logic [3*NCH-1:0] cap_ctrl;
      logic [NCH-1:0][31:0] cap_val;
      logic [NCH-1:0] ext_state;
      logic [2*NCH-1:0] ext_act;
      logic [1:0] cnt_mode;
      logic [15:0] cap_route;
      logic [NCH-1:0] cap_and;
      logic [2*NPIN-1:0] out_route;
      logic [2*NCH-1:0] flags;
      logic ext_prev;
      logic irq;
      logic [NPIN-1:0] pins_out;
      logic [31:0] rdata;
      logic err;
      logic ready;
   } cmt_state_t;

   cmt_state_t s;
   cmt_state_t next_s;

   cmt_cap_if cap ();

   // capture pins and routing go to the capture unit
   assign cap.pins = cap_pin;
   assign cap.sel = s.cap_route;
   assign cap.and_mode = s.cap_and;
   generate
      for (genvar i = 0; i < NCH; i++) begin : g_cc
         assign cap.rise_en[i] = s.cap_ctrl[3*i+cmt_pkg::CC_RISE];
         assign cap.fall_en[i] = s.cap_ctrl[3*i+cmt_pkg::CC_FALL];
      end
   endgenerate

   cmt_capture_unit u_cap (
      .pclk(pclk),
      .presetn(presetn),
      .cap(cap.unit)
   );

   // one process holds all next-state logic of the block
   always_comb begin
      logic tick;
      logic ext_rise;
      logic ext_fall;
      logic wr;
      logic [2*NCH-1:0] set_f;
      logic [2*NCH-1:0] clr_f;
      logic [1:0] act;
      logic [1:0] osel;
      logic [31:0] rd;
      logic hit;
      next_s = s;
      set_f = '0;
      clr_f = '0;
      rd = cmt_pkg::RST_WORD;
      hit = 1'b1;
      tick = 1'b0;
      act = cmt_pkg::ACT_HOLD;
      osel = 2'h0;
      wr = psel & penable & pwrite & s.ready;

      // counting source: pclk or sampled external clock edges
      ext_rise = cnt_clk_in & ~s.ext_prev;
      ext_fall = ~cnt_clk_in & s.ext_prev;
      next_s.ext_prev = cnt_clk_in;
      unique case (s.cnt_mode)
         cmt_pkg::MODE_PCLK: tick = 1'b1;
         cmt_pkg::MODE_EXT_RISE: tick = ext_rise;        // [RULE8]
         cmt_pkg::MODE_EXT_FALL: tick = ext_fall;        // [RULE8]
         cmt_pkg::MODE_EXT_BOTH: tick = ext_rise | ext_fall; // [RULE8]
      endcase

      // prescaler then counter; matches are judged as the counter steps
      if (s.en && !s.cnt_rst && tick) begin
         if (s.pre_cnt == s.pre_lim) begin
            next_s.pre_cnt = cmt_pkg::RST_WORD;                 // [RULE11]
            next_s.count = s.count + 32'h0000_0001;             // [RULE1] [RULE11]
            for (int i = 0; i < NCH; i++) begin
               if (s.count == s.match_val[i]) begin             // [RULE3]
                  if (s.match_ctrl[3*i+cmt_pkg::MC_INT]) begin
                     set_f[i] = 1'b1;                          // [RULE4]
                  end
                  if (s.match_ctrl[3*i+cmt_pkg::MC_RST]) begin
                     next_s.count = cmt_pkg::RST_WORD;          // [RULE6]
                  end
                  if (s.match_ctrl[3*i+cmt_pkg::MC_STOP]) begin
                     next_s.en = 1'b0;                          // [RULE5]
                  end
                  act = s.ext_act[2*i +: 2];
                  unique case (act)
                     cmt_pkg::ACT_HOLD: next_s.ext_state[i] = s.ext_state[i]; // [RULE7]
                     cmt_pkg::ACT_LOW: next_s.ext_state[i] = 1'b0;            // [RULE7]
                     cmt_pkg::ACT_HIGH: next_s.ext_state[i] = 1'b1;           // [RULE7]
                     cmt_pkg::ACT_TOGGLE: next_s.ext_state[i] = ~s.ext_state[i]; // [RULE7]
                  endcase
               end
            end
         end else begin
            next_s.pre_cnt = s.pre_cnt + 32'h0000_0001;         // [RULE1] [RULE11]
         end
      end

      // held reset keeps counter and prescaler at zero
      if (s.cnt_rst) begin
         next_s.count = cmt_pkg::RST_WORD;
         next_s.pre_cnt = cmt_pkg::RST_WORD;
      end

      // captures snapshot the count of the cycle after the transition, when the registered hit arrives
      for (int i = 0; i < NCH; i++) begin
         if (cap.event_hit[i]) begin
            next_s.cap_val[i] = s.count;                        // [RULE2]
            if (s.cap_ctrl[3*i+cmt_pkg::CC_INT]) begin
               set_f[cmt_pkg::FL_CAP+i] = 1'b1;                 // [RULE2]
            end
         end
      end

      // register writes take effect at the access edge; software wins, except that a flag set beats its clear
      if (wr) begin
         unique case (paddr)
            cmt_pkg::OFS_FLAGS: clr_f = pwdata[2*NCH-1:0];
            cmt_pkg::OFS_CTRL: begin
               next_s.en = pwdata[cmt_pkg::CTRL_EN];
               next_s.cnt_rst = pwdata[cmt_pkg::CTRL_RST];
            end
            cmt_pkg::OFS_COUNT: next_s.count = pwdata;
            cmt_pkg::OFS_PRE_LIM: next_s.pre_lim = pwdata;
            cmt_pkg::OFS_PRE_CNT: next_s.pre_cnt = pwdata;
            cmt_pkg::OFS_MATCH_CTRL: next_s.match_ctrl = pwdata[3*NCH-1:0];
            cmt_pkg::OFS_CAP_CTRL: next_s.cap_ctrl = pwdata[3*NCH-1:0];
            cmt_pkg::OFS_EXT_MATCH: begin
               next_s.ext_state = pwdata[NCH-1:0];
               next_s.ext_act = pwdata[cmt_pkg::EM_ACT +: 2*NCH];
            end
            cmt_pkg::OFS_CNT_MODE: next_s.cnt_mode = pwdata[1:0];
            cmt_pkg::OFS_CAP_ROUTE: begin
               next_s.cap_route = pwdata[15:0];
               next_s.cap_and = pwdata[cmt_pkg::CR_AND +: NCH];
            end
            cmt_pkg::OFS_OUT_ROUTE: next_s.out_route = pwdata[2*NPIN-1:0];
            default: begin
               for (int i = 0; i < NCH; i++) begin
                  if (paddr == cmt_pkg::OFS_MATCH0 + 8'(4*i)) begin
                     next_s.match_val[i] = pwdata;
                  end
               end
            end
         endcase
      end

      // sticky flags: a set in the clearing cycle survives
      next_s.flags = (s.flags & ~clr_f) | set_f;
      next_s.irq = |next_s.flags;                               // [RULE10]

      // each pin shows the match output chosen for it
      for (int j = 0; j < NPIN; j++) begin
         osel = s.out_route[2*j +: 2];
         next_s.pins_out[j] = next_s.ext_state[osel];           // [RULE9] [RULE7]
      end

      // read data and error are latched in the setup cycle
      unique case (paddr)
         cmt_pkg::OFS_FLAGS: rd = 32'(s.flags);
         cmt_pkg::OFS_CTRL: rd = 32'({s.cnt_rst, s.en});
         cmt_pkg::OFS_COUNT: rd = s.count;
         cmt_pkg::OFS_PRE_LIM: rd = s.pre_lim;
         cmt_pkg::OFS_PRE_CNT: rd = s.pre_cnt;
         cmt_pkg::OFS_MATCH_CTRL: rd = 32'(s.match_ctrl);
         cmt_pkg::OFS_CAP_CTRL: rd = 32'(s.cap_ctrl);
         cmt_pkg::OFS_EXT_MATCH: rd = 32'({s.ext_act, s.ext_state});
         cmt_pkg::OFS_CNT_MODE: rd = 32'(s.cnt_mode);
         cmt_pkg::OFS_CAP_ROUTE: rd = 32'({s.cap_and, s.cap_route});
         cmt_pkg::OFS_OUT_ROUTE: rd = 32'(s.out_route);
         default: begin
            hit = 1'b0;
            for (int i = 0; i < NCH; i++) begin
               if (paddr == cmt_pkg::OFS_MATCH0 + 8'(4*i)) begin
                  rd = s.match_val[i];
                  hit = 1'b1;
               end
               if (paddr == cmt_pkg::OFS_CAP0 + 8'(4*i)) begin
                  rd = s.cap_val[i];
                  hit = 1'b1;
               end
            end
         end
      endcase
      // unaligned addresses are unmapped too
      if (paddr[1:0] != 2'h0) begin
         hit = 1'b0;
      end
      if (psel && !penable) begin
         next_s.rdata = hit ? rd : cmt_pkg::RST_WORD;
         next_s.err = ~hit;
      end
      next_s.ready = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.cap_route <= cmt_pkg::RST_CAP_ROUTE;
         s.out_route <= cmt_pkg::RST_OUT_ROUTE;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign prdata = s.rdata;
   assign pready = s.ready;
   assign pslverr = s.err;
   assign match_pin = s.pins_out;
   assign irq = s.irq;
endmodule // cmt_timer
`default_nettype wire

// ### verification/capture_match_timer_bench.sv
// self-checking bench of the capture/match timer: apb tasks, pin model, random counts
// assumes the checker is bound to the timer from its own file
`default_nettype none
module capture_match_timer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, cnt_clk_in, irq, e;
   logic [3:0] cap_lvl = 4'h0, cap_pin, match_pin;
   int n_mismatch = 0, compares = 0, m, l, n;
   always #2.5 pclk = ~pclk;
   cmt_timer u_cmt_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cap_pin(cap_pin), .cnt_clk_in(cnt_clk_in), .match_pin(match_pin),
      .irq(irq));
   cmt_pin_model u_cmt_pin_model (.pclk(pclk), .presetn(presetn), .cap_lvl(cap_lvl),
      .cap_pin(cap_pin), .cnt_clk_in(cnt_clk_in));
   // expected ticks up to a match, and pin level after an action from low
   function automatic logic [31:0] ticks(input int mv, input int lv);
      return 32'((mv + 1) * (lv + 1));
   endfunction
   function automatic logic [31:0] pin_exp(input int act);
      return {31'h0, act >= int'(cmt_pkg::ACT_HIGH)};
   endfunction
   task chk(input logic [31:0] s, input logic [31:0] x, input string nm);
      compares++;
      if (s !== x) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, x, s);
      end
   endtask
   // one transfer; the release edge leaves an idle cycle before the next
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rc(input logic [7:0] a, input logic [31:0] x, input string nm);
      apb(1'b0, a, 32'h0);
      chk(r, x, nm);
   endtask
   // bounded wait for the request line, counting edges
   task wirq();
      n = 0;
      while (irq !== 1'b1 && n < 500) begin
         @(posedge pclk);
         #1;
         n++;
      end
   endtask
   task test_done();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // watchdog: the run needs well under 10000 cycles
   initial begin
      #100000;
      n_mismatch++;
      test_done();
   end
   initial begin
      void'($urandom(32'hf0c9));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rc(8'h44, 32'h8421, "cap_route");
      rc(8'h48, 32'he4, "out_route");
      rc(8'h4c, 32'h0, "unmapped");
      chk({31'h0, e}, 32'h1, "slverr");
      rc(8'h05, 32'h0, "unaligned");
      chk({31'h0, e}, 32'h1, "slverr_unal");
      wr(8'h3c, 32'h1);
      wr(8'h48, 32'h0);
      // the new route reaches the pins one edge after the write lands
      @(posedge pclk);
      #1;
      chk({28'h0, match_pin}, 32'hf, "broadcast");
      wr(8'h48, 32'he4);
      $display("test reset done");
      // channel 0 or of pin 0, channel 1 and of pins 1 and 2, counter held
      wr(8'h08, 32'h1234);
      wr(8'h44, 32'h0002_0061);
      wr(8'h28, 32'h2d);
      @(posedge pclk);
      cap_lvl <= 4'h3;
      repeat (6) @(posedge pclk);
      rc(8'h00, 32'h10, "and_wait");
      rc(8'h2c, 32'h1234, "cap0");
      wr(8'h08, 32'h5678);
      @(posedge pclk);
      cap_lvl <= 4'h7;
      repeat (6) @(posedge pclk);
      rc(8'h00, 32'h30, "and_hit");
      rc(8'h30, 32'h5678, "cap1");
      chk({31'h0, irq}, 32'h1, "irq_cap");
      wr(8'h00, 32'hff);
      chk({31'h0, irq}, 32'h0, "irq_clr");
      $display("test capture done");
      // stop on match under every output action, random limit and match
      for (int a = 0; a < 4; a++) begin
         m = $urandom_range(7);
         l = $urandom_range(3);
         wr(8'h08, 32'h0);
         wr(8'h10, 32'h0);
         wr(8'h0c, 32'(l));
         wr(8'h18, 32'(m));
         wr(8'h14, 32'h5);
         wr(8'h3c, 32'(a) << cmt_pkg::EM_ACT);
         wr(8'h04, 32'h1);
         wirq();
         chk(32'(n), ticks(m, l), "ticks");
         rc(8'h08, 32'(m + 1), "stop_count");
         rc(8'h04, 32'h0, "stopped");
         chk({31'h0, match_pin[0]}, pin_exp(a), "action");
         wr(8'h00, 32'hff);
      end
      $display("test stop done");
      // channel 2 flags only, channel 1 flags and resets the count
      m = 16 + $urandom_range(7);
      wr(8'h08, 32'h0);
      wr(8'h0c, 32'h0);
      wr(8'h1c, 32'(m));
      wr(8'h20, 32'h2);
      wr(8'h14, 32'h58);
      wr(8'h04, 32'h1);
      wirq();
      chk(32'(n), ticks(2, 0), "run_ticks");
      rc(8'h04, 32'h1, "running");
      wr(8'h00, 32'hff);
      wirq();
      rc(8'h00, 32'h2, "reset_flag");
      wr(8'h04, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk({31'h0, r < 32'(m)}, 32'h1, "wrapped");
      $display("test periodic done");
      // every external edge mode as the count source, clock idle low between bursts
      wr(8'h14, 32'h0);
      wr(8'h04, 32'h1);
      for (int k = 1; k < 4; k++) begin
         wr(8'h40, 32'(k));
         rc(8'h40, 32'(k), "mode");
         wr(8'h08, 32'h0);
         m = 1 + $urandom_range(9);
         u_cmt_pin_model.pulse(m);
         repeat (4) @(posedge pclk);
         rc(8'h08, 32'(k == int'(cmt_pkg::MODE_EXT_BOTH) ? 2 * m : m), "ext_count");
      end
      // held counter reset keeps the count at zero
      wr(8'h04, 32'h3);
      rc(8'h08, 32'h0, "held_reset");
      $display("test counting done");
      test_done();
   end
endmodule // capture_match_timer_bench
`default_nettype wire

// ### verification/cmt_pin_model.sv
// model of the pins facing the timer: capture levels and an external count clock
// assumes the bench sets the wanted capture levels; all synchronous to pclk
`default_nettype none
module cmt_pin_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // wanted capture levels
   input wire logic [cmt_pkg::NPIN-1:0] cap_lvl,
   // to the timer
   output logic [cmt_pkg::NPIN-1:0] cap_pin,
   output logic cnt_clk_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // pins move just after an edge, like any synchronous source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_pin <= 4'h0;
      end else begin
         cap_pin <= cap_lvl;
      end
   end
   // count clock stands low between bursts, so only commanded edges count
   initial cnt_clk_in = 1'b0;
   task automatic pulse(input int k);
      for (int i = 0; i < 2 * k; i++) begin
         repeat (3) @(posedge pclk);
         cnt_clk_in <= ~cnt_clk_in;
      end
   endtask
endmodule // cmt_pin_model
`default_nettype wire

// ### verification/cmt_timer_properties.sv
// checker of the timer's bus answers and merged request line
// assumes it is bound to cmt_timer; one clock domain
`default_nettype none
module cmt_timer_properties (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // request line
   input wire logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // setup cycle, flag clearing write and read access
   logic su;
   logic clr;
   logic rd;
   assign su = psel && !penable;
   assign clr = psel && penable && pwrite && paddr == cmt_pkg::OFS_FLAGS;
   assign rd = psel && penable && !pwrite && !pslverr;
   property p_ready_up; $past(presetn) |-> pready; endproperty
   a_ready_up: assert property (p_ready_up) else $error("pready low");
   property p_err_unal; su && paddr[1:0] != 2'h0 |=> pslverr; endproperty
   a_err_unal: assert property (p_err_unal) else $error("no error unaligned");
   property p_err_map; su && paddr > cmt_pkg::OFS_LAST |=> pslverr && prdata == 32'h0; endproperty
   a_err_map: assert property (p_err_map) else $error("no error unmapped");
   property p_ok_map; su && paddr[1:0] == 2'h0 && paddr <= cmt_pkg::OFS_LAST |=> !pslverr;
   endproperty
   a_ok_map: assert property (p_ok_map) else $error("error on mapped");
   property p_stand; !su |=> $stable({prdata, pslverr}); endproperty
   a_stand: assert property (p_stand) else $error("read data moved");
   property p_irq_clr; $fell(irq) |-> $past(clr); endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("irq fell alone");
   property p_flag_w; rd && paddr == cmt_pkg::OFS_FLAGS |-> prdata[31:8] == 24'h0; endproperty
   a_flag_w: assert property (p_flag_w) else $error("flags too wide");
   property p_mode_w; rd && paddr == cmt_pkg::OFS_CNT_MODE |-> prdata[31:2] == 30'h0;
   endproperty
   a_mode_w: assert property (p_mode_w) else $error("mode too wide");
endmodule // cmt_timer_properties
bind cmt_timer cmt_timer_properties u_cmt_timer_properties (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire
